// ---- design/cpusc_map.vh ----
`ifndef CPUSC_MAP_VH
`define CPUSC_MAP_VH
// ----------------------------------------
// Register word offsets (byte address = 4 x index)
// ----------------------------------------
`define CPUSC_IDX_STATUS 4'hC
`define CPUSC_IDX_CAUSE 4'hD
// ----------------------------------------
// Status field positions
// ----------------------------------------
`define CPUSC_ST_CU_HI 31
`define CPUSC_ST_CU_LO 28
`define CPUSC_ST_FR 26
`define CPUSC_ST_DEV 23
`define CPUSC_ST_BEV 22
`define CPUSC_ST_CH 18
`define CPUSC_ST_EDI 17
`define CPUSC_ST_EIE 16
`define CPUSC_ST_IM7 15
`define CPUSC_ST_BEM 12
`define CPUSC_ST_IM3 11
`define CPUSC_ST_IM2 10
`define CPUSC_ST_KSU_HI 4
`define CPUSC_ST_KSU_LO 3
`define CPUSC_ST_ERL 2
`define CPUSC_ST_EXL 1
`define CPUSC_ST_IE 0
// Writable bits; reserved bits stay zero
`define CPUSC_ST_WMASK 32'hF4C79C1F
// Reset value: boot vector and error level set, all else zero
`define CPUSC_ST_RESET 32'h00400004
// ----------------------------------------
// Cause field positions
// ----------------------------------------
`define CPUSC_CA_BD 31
`define CPUSC_CA_BD2 30
`define CPUSC_CA_CE_HI 29
`define CPUSC_CA_CE_LO 28
`define CPUSC_CA_L2_HI 18
`define CPUSC_CA_L2_LO 16
`define CPUSC_CA_IP7 15
`define CPUSC_CA_IP3 11
`define CPUSC_CA_IP2 10
// ----------------------------------------
// Encodings
// ----------------------------------------
`define CPUSC_KSU_KERNEL 2'h0
`define CPUSC_KSU_SUPER 2'h1
`define CPUSC_KSU_USER 2'h2
`define CPUSC_L2_RESET 3'h0
`define CPUSC_L2_NMI 3'h1
`define CPUSC_L2_PERF 3'h2
`define CPUSC_L2_DEBUG 3'h3
`define CPUSC_RD_UNMAPPED 32'h00000000
`endif

// ---- design/cpusc_top.v ----
// Notes on behaviour
// RL1: Four usability bits, one per coprocessor; unit zero always usable in kernel mode.
// RL2: Register extension bit selects 16 or 32 float registers; resets to zero.
// RL3: Debug vector select picks normal or bootstrap for perf and debug vectors.
// RL4: Boot vector bit picks normal or bootstrap for refill and general; resets one.
// RL5: Cache hit flag records hit or miss of last data hit-invalidate op.
// RL6: Permission bit lets enable/disable-interrupt act in all modes, else kernel only.
// RL7: Master gate cleared by disable, set by enable; zero blocks all interrupts.
// RL8: Interrupts enabled only with enable and gate set, both levels clear.
// RL9: Interrupt taken only when enabled and matching mask and pending bits set.
// RL10: Bus error with mask clear updates address, raises exception, sets mask.
// RL11: Privilege field 00 kernel 01 super 10 user; levels force kernel.
// RL12: Error level set on reset, NMI, perf, serial-debug, debug; resets one.
// RL13: Exception level set on every exception except reset, NMI, perf, debug.
// RL14: Serial-debug request raises debug exception only while error level clear.
// RL15: Kernel space kernel only, supervisor space kernel or super, user space all.
// RL16: Unused status bits read zero; software writes zero there.
// RL17: Cause word reports latest exception and is read-only to software.
// RL18: Delay-slot flag set on level-1 exception in delay slot, else cleared.
// RL19: Second delay-slot flag shows level-2 exception taken in delay slot.
// RL20: Coprocessor-unusable exception captures referenced coprocessor number.
// RL21: Level-2 code: 000 reset, 001 NMI, 010 performance counter.
// RL22: Level-2 code 011 for debug and serial-debug; 4 to 7 reserved.
// RL23: Pending bits 15, 11:10 read one while their source is pending.
// RL24: Mask bit 7 is timer interrupt; mask bits 3:2 are external inputs.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cpusc_map.vh"

module cpusc_top #(
    parameter ADDR_W = 4,
    parameter PADDR_W = 32
) (
    // Clock and reset
    input wire CLK_SYS,
    input wire RESET,
    // Avalon-MM slave
    input wire [ADDR_W-1:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    // Interrupt sources
    input wire TIMER_INT,
    input wire [1:0] EXT_INT,
    // Instruction and cache events from the pipeline
    input wire GLOBAL_INT_SET_INSN,
    input wire GLOBAL_INT_CLEAR_INSN,
    input wire CACHE_HIT_OP_DONE,
    input wire CACHE_HIT_RESULT,
    // Bus error report
    input wire BUS_ERROR,
    input wire [PADDR_W-1:0] BUS_ERROR_ADDR,
    // Exception taken by the pipeline
    input wire EXC_L1_TAKEN,
    input wire EXC_CPU_UNUSABLE,
    input wire [1:0] EXC_COPROC_NUM,
    input wire EXC_L2_TAKEN,
    input wire [2:0] EXC_L2_CODE,
    input wire EXC_IN_DELAY_SLOT,
    input wire SERIAL_DEBUG_REQUEST,
    // Status decodes and captured bus fault address
    output wire INTERRUPT_TAKE,
    output wire BUS_ERROR_EXCEPTION,
    output wire SERIAL_DEBUG_EXCEPTION,
    output wire [3:0] COPROC_USABLE,
    output wire FP_REGFILE_32,
    output wire DEBUG_VECTOR_BOOT,
    output wire GENERAL_VECTOR_BOOT,
    output wire MODE_KERNEL,
    output wire MODE_SUPERVISOR,
    output wire MODE_USER,
    output wire KERNEL_SPACE_OK,
    output wire SUPER_SPACE_OK,
    output wire USER_SPACE_OK,
    output reg [PADDR_W-1:0] BUS_FAULT_PHYS_ADDRESS
);

// ----------------------------------------
// Storage
// ----------------------------------------
reg [31:0] status_ff;
reg delay_slot_flag_ff;
reg level2_delay_slot_flag_ff;
reg [1:0] fault_coproc_ff;
reg [2:0] level2_cause_code_ff;
reg [31:0] nxt_status;
wire [31:0] byte_mask;
reg read_wait_done_ff;
genvar g;

wire [2:0] interrupt_pending_bits = {TIMER_INT, EXT_INT}; // RL23 RL24
wire [2:0] interrupt_mask_bits = {status_ff[`CPUSC_ST_IM7], status_ff[`CPUSC_ST_IM3],
    status_ff[`CPUSC_ST_IM2]}; // RL24
wire global_int_enable = status_ff[`CPUSC_ST_IE];
wire interrupt_master_gate = status_ff[`CPUSC_ST_EIE];
wire error_level = status_ff[`CPUSC_ST_ERL];
wire exception_level = status_ff[`CPUSC_ST_EXL];
wire bus_error_mask = status_ff[`CPUSC_ST_BEM];
wire [1:0] privilege_mode_field = status_ff[`CPUSC_ST_KSU_HI:`CPUSC_ST_KSU_LO];
wire unpriv_int_toggle_allow = status_ff[`CPUSC_ST_EDI];

// ----------------------------------------
// Mode and enable decode
// ----------------------------------------
wire levels_clear = ~exception_level & ~error_level;
assign MODE_USER = levels_clear & (privilege_mode_field == `CPUSC_KSU_USER); // RL11
assign MODE_SUPERVISOR = levels_clear & (privilege_mode_field == `CPUSC_KSU_SUPER); // RL11
// Reserved privilege code with levels clear is treated as kernel
assign MODE_KERNEL = ~MODE_USER & ~MODE_SUPERVISOR; // RL11
assign KERNEL_SPACE_OK = MODE_KERNEL; // RL15
assign SUPER_SPACE_OK = MODE_KERNEL | MODE_SUPERVISOR; // RL15
assign USER_SPACE_OK = 1'b1; // RL15

wire ints_enabled = global_int_enable & interrupt_master_gate & levels_clear; // RL8
assign INTERRUPT_TAKE = ints_enabled
    & |(interrupt_mask_bits & interrupt_pending_bits); // RL9
assign BUS_ERROR_EXCEPTION = BUS_ERROR & ~bus_error_mask; // RL10
assign SERIAL_DEBUG_EXCEPTION = SERIAL_DEBUG_REQUEST & ~error_level; // RL14

assign COPROC_USABLE = status_ff[`CPUSC_ST_CU_HI:`CPUSC_ST_CU_LO]
    | {3'h0, MODE_KERNEL}; // RL1
assign FP_REGFILE_32 = status_ff[`CPUSC_ST_FR]; // RL2
assign DEBUG_VECTOR_BOOT = status_ff[`CPUSC_ST_DEV]; // RL3
assign GENERAL_VECTOR_BOOT = status_ff[`CPUSC_ST_BEV]; // RL4

// Toggle instructions only change the master gate when permitted
wire toggle_ok = unpriv_int_toggle_allow | MODE_KERNEL; // RL6

// ----------------------------------------
// Bus slave: writes take no wait state, reads one
// ----------------------------------------
// Read data comes from a flop, so a read waits one cycle and the word
// then stands in the very cycle in which waitrequest is low
assign AVS_WAITREQUEST = AVS_READ & ~read_wait_done_ff;
wire status_wr = AVS_WRITE & (AVS_ADDRESS == `CPUSC_IDX_STATUS);

always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
        read_wait_done_ff <= 1'b0;
    end else begin
        read_wait_done_ff <= AVS_READ & ~read_wait_done_ff;
    end
end

generate
    for (g = 0; g < 32; g = g + 1) begin : g_lane
        assign byte_mask[g] = AVS_BYTEENABLE[g / 8];
    end
endgenerate

// ----------------------------------------
// Status next value
// ----------------------------------------
// Hardware events are applied after the software write so that they win
always @* begin
    nxt_status = status_ff;
    if (status_wr) begin
        nxt_status = ((AVS_WRITEDATA & byte_mask) | (status_ff & ~byte_mask))
            & `CPUSC_ST_WMASK; // RL16
    end
    if (CACHE_HIT_OP_DONE) begin
        nxt_status[`CPUSC_ST_CH] = CACHE_HIT_RESULT; // RL5
    end
    if (toggle_ok && GLOBAL_INT_CLEAR_INSN) begin
        nxt_status[`CPUSC_ST_EIE] = 1'b0; // RL7
    end else if (toggle_ok && GLOBAL_INT_SET_INSN) begin
        nxt_status[`CPUSC_ST_EIE] = 1'b1; // RL7
    end
    if (BUS_ERROR_EXCEPTION) begin
        nxt_status[`CPUSC_ST_BEM] = 1'b1; // RL10
    end
    if (EXC_L1_TAKEN) begin
        nxt_status[`CPUSC_ST_EXL] = 1'b1; // RL13
    end
    if (EXC_L2_TAKEN || SERIAL_DEBUG_EXCEPTION) begin
        nxt_status[`CPUSC_ST_ERL] = 1'b1; // RL12
    end
end

always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
        status_ff <= `CPUSC_ST_RESET; // RL2 RL4 RL12
    end else begin
        status_ff <= nxt_status;
    end
end

// ----------------------------------------
// Cause capture and bad address
// ----------------------------------------
always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
        delay_slot_flag_ff <= 1'b0;
        level2_delay_slot_flag_ff <= 1'b0;
        fault_coproc_ff <= 2'h0;
        level2_cause_code_ff <= `CPUSC_L2_RESET;
        BUS_FAULT_PHYS_ADDRESS <= {PADDR_W{1'b0}};
    end else begin
        if (BUS_ERROR_EXCEPTION) begin
            BUS_FAULT_PHYS_ADDRESS <= BUS_ERROR_ADDR; // RL10
        end
        if (EXC_L1_TAKEN) begin
            delay_slot_flag_ff <= EXC_IN_DELAY_SLOT; // RL18
            if (EXC_CPU_UNUSABLE) begin
                fault_coproc_ff <= EXC_COPROC_NUM; // RL20
            end
        end
        if (SERIAL_DEBUG_EXCEPTION) begin
            level2_delay_slot_flag_ff <= EXC_IN_DELAY_SLOT; // RL19
            level2_cause_code_ff <= `CPUSC_L2_DEBUG; // RL22
        end else if (EXC_L2_TAKEN && !EXC_L2_CODE[2]) begin
            // Reserved codes 4 to 7 are not recorded
            level2_delay_slot_flag_ff <= EXC_IN_DELAY_SLOT; // RL19
            level2_cause_code_ff <= EXC_L2_CODE; // RL21 RL22
        end
    end
end

// ----------------------------------------
// Read path; cause has no write path at all
// ----------------------------------------
reg [31:0] cause_word;
always @* begin
    cause_word = 32'h00000000;
    cause_word[`CPUSC_CA_BD] = delay_slot_flag_ff;
    cause_word[`CPUSC_CA_BD2] = level2_delay_slot_flag_ff;
    cause_word[`CPUSC_CA_CE_HI:`CPUSC_CA_CE_LO] = fault_coproc_ff;
    cause_word[`CPUSC_CA_L2_HI:`CPUSC_CA_L2_LO] = level2_cause_code_ff;
    cause_word[`CPUSC_CA_IP7] = interrupt_pending_bits[2]; // RL23
    cause_word[`CPUSC_CA_IP3] = interrupt_pending_bits[1]; // RL23
    cause_word[`CPUSC_CA_IP2] = interrupt_pending_bits[0]; // RL23
end

always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
        AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ && !read_wait_done_ff) begin
        if (AVS_ADDRESS == `CPUSC_IDX_STATUS) begin
            AVS_READDATA <= status_ff & `CPUSC_ST_WMASK; // RL16
        end else if (AVS_ADDRESS == `CPUSC_IDX_CAUSE) begin
            AVS_READDATA <= cause_word; // RL17
        end else begin
            AVS_READDATA <= `CPUSC_RD_UNMAPPED;
        end
    end
end

endmodule

// ---- tb/cpusc_chk.sv ----
`timescale 1ns/1ps
module cpusc_chk #(
    parameter PADDR_W = 32
) (
    // Clock, reset and pipeline inputs
    input wire CLK_SYS,
    input wire RESET,
    input wire TIMER_INT,
    input wire [1:0] EXT_INT,
    input wire BUS_ERROR,
    input wire [PADDR_W-1:0] BUS_ERROR_ADDR,
    input wire EXC_L1_TAKEN,
    input wire EXC_L2_TAKEN,
    input wire SERIAL_DEBUG_REQUEST,
    // Decoded outputs
    input wire INTERRUPT_TAKE,
    input wire BUS_ERROR_EXCEPTION,
    input wire SERIAL_DEBUG_EXCEPTION,
    input wire [3:0] COPROC_USABLE,
    input wire MODE_KERNEL,
    input wire MODE_SUPERVISOR,
    input wire MODE_USER,
    input wire KERNEL_SPACE_OK,
    input wire SUPER_SPACE_OK,
    input wire USER_SPACE_OK,
    input wire [PADDR_W-1:0] BUS_FAULT_PHYS_ADDRESS
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    property p_int; INTERRUPT_TAKE |-> TIMER_INT || EXT_INT != 2'h0; endproperty
    a_int: assert property (p_int) else $error("take without pending");
    property p_bee;
        BUS_ERROR_EXCEPTION |-> BUS_ERROR ##1 BUS_FAULT_PHYS_ADDRESS == $past(BUS_ERROR_ADDR);
    endproperty
    a_bee: assert property (p_bee) else $error("fault address not captured");
    property p_hold; !BUS_ERROR_EXCEPTION |=> $stable(BUS_FAULT_PHYS_ADDRESS); endproperty
    a_hold: assert property (p_hold) else $error("fault address moved");
    property p_sdx;
        SERIAL_DEBUG_EXCEPTION |-> SERIAL_DEBUG_REQUEST ##1 MODE_KERNEL && !SERIAL_DEBUG_EXCEPTION;
    endproperty
    a_sdx: assert property (p_sdx) else $error("serial debug not gated");
    property p_l2; EXC_L2_TAKEN |=> MODE_KERNEL && !INTERRUPT_TAKE; endproperty
    a_l2: assert property (p_l2) else $error("level two left user mode");
    property p_l1; EXC_L1_TAKEN |=> MODE_KERNEL && !INTERRUPT_TAKE; endproperty
    a_l1: assert property (p_l1) else $error("exception left user mode");
    property p_mode; $onehot({MODE_KERNEL, MODE_SUPERVISOR, MODE_USER}); endproperty
    a_mode: assert property (p_mode) else $error("modes not exclusive");
    property p_space;
        KERNEL_SPACE_OK == MODE_KERNEL && USER_SPACE_OK
            && SUPER_SPACE_OK == (MODE_KERNEL || MODE_SUPERVISOR);
    endproperty
    a_space: assert property (p_space) else $error("space rights wrong");
    property p_cu0; MODE_KERNEL |-> COPROC_USABLE[0]; endproperty
    a_cu0: assert property (p_cu0) else $error("unit zero unusable in kernel");
    c_int: cover property (INTERRUPT_TAKE);
    c_bee: cover property (BUS_ERROR_EXCEPTION);
    c_sdx: cover property (SERIAL_DEBUG_EXCEPTION);
endmodule
bind cpusc_top cpusc_chk #(.PADDR_W(PADDR_W)) cpusc_chk_inst (.CLK_SYS(CLK_SYS),
    .RESET(RESET), .TIMER_INT(TIMER_INT), .EXT_INT(EXT_INT), .BUS_ERROR(BUS_ERROR),
    .BUS_ERROR_ADDR(BUS_ERROR_ADDR), .EXC_L1_TAKEN(EXC_L1_TAKEN), .EXC_L2_TAKEN(EXC_L2_TAKEN),
    .SERIAL_DEBUG_REQUEST(SERIAL_DEBUG_REQUEST), .INTERRUPT_TAKE(INTERRUPT_TAKE),
    .BUS_ERROR_EXCEPTION(BUS_ERROR_EXCEPTION), .SERIAL_DEBUG_EXCEPTION(SERIAL_DEBUG_EXCEPTION),
    .COPROC_USABLE(COPROC_USABLE), .MODE_KERNEL(MODE_KERNEL), .MODE_SUPERVISOR(MODE_SUPERVISOR),
    .MODE_USER(MODE_USER), .KERNEL_SPACE_OK(KERNEL_SPACE_OK), .SUPER_SPACE_OK(SUPER_SPACE_OK),
    .USER_SPACE_OK(USER_SPACE_OK), .BUS_FAULT_PHYS_ADDRESS(BUS_FAULT_PHYS_ADDRESS));

// ---- tb/cpusc_pipe.sv ----
`timescale 1ns/1ps
module cpusc_pipe (
    // Clock
    input wire clk,
    // Pulses, levels, fault address
    output reg [5:0] ev_ff,
    output reg [11:0] lv_ff,
    output reg [31:0] addr_ff
);
    initial begin
        ev_ff = 6'h00;
        lv_ff = 12'h000;
        addr_ff = 32'h00000000;
    end
    // Address is inverted after its cycle so a stale value is never trusted
    task pulse(input [5:0] e, input [11:0] l, input [31:0] a);
        begin
            @(posedge clk);
            ev_ff <= e;
            lv_ff <= l;
            addr_ff <= a;
            @(posedge clk);
            ev_ff <= 6'h00;
            addr_ff <= ~a;
        end
    endtask
endmodule

// ---- tb/cpusc_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count = check_count + 1; if ((s) !== (e)) begin \
    error_cnt = error_cnt + 1; $display("unexpected %s exp %h got %h", n, e, s); end end
module cpusc_top_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] a_addr = 4'h0;
    reg a_rd = 1'b0;
    reg a_wr = 1'b0;
    reg [31:0] a_wd = 32'h00000000;
    reg [31:0] rdat;
    wire [31:0] rd_data, bfa, be_addr;
    wire wait_req, take, fp32, dvb, gvb, mk, ms, mu;
    wire [3:0] cu;
    wire [5:0] ev;
    wire [11:0] lv;
    integer error_cnt = 0;
    integer check_count = 0;
    integer k;
    initial forever #2.5 clk = ~clk;
    cpusc_pipe cpusc_pipe_inst (.clk(clk), .ev_ff(ev), .lv_ff(lv), .addr_ff(be_addr));
    cpusc_top cpusc_top_inst (.CLK_SYS(clk), .RESET(rst), .AVS_ADDRESS(a_addr), .AVS_READ(a_rd),
        .AVS_WRITE(a_wr), .AVS_WRITEDATA(a_wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rd_data),
        .AVS_WAITREQUEST(wait_req), .TIMER_INT(lv[11]), .EXT_INT(lv[10:9]),
        .GLOBAL_INT_SET_INSN(ev[0]), .GLOBAL_INT_CLEAR_INSN(ev[1]), .CACHE_HIT_OP_DONE(ev[2]),
        .CACHE_HIT_RESULT(lv[6]), .BUS_ERROR(ev[3]), .BUS_ERROR_ADDR(be_addr),
        .EXC_L1_TAKEN(ev[4]), .EXC_CPU_UNUSABLE(lv[5]), .EXC_COPROC_NUM(lv[4:3]),
        .EXC_L2_TAKEN(ev[5]), .EXC_L2_CODE(lv[2:0]), .EXC_IN_DELAY_SLOT(lv[7]),
        .SERIAL_DEBUG_REQUEST(lv[8]), .INTERRUPT_TAKE(take), .BUS_ERROR_EXCEPTION(),
        .SERIAL_DEBUG_EXCEPTION(), .COPROC_USABLE(cu), .FP_REGFILE_32(fp32),
        .DEBUG_VECTOR_BOOT(dvb), .GENERAL_VECTOR_BOOT(gvb), .MODE_KERNEL(mk),
        .MODE_SUPERVISOR(ms), .MODE_USER(mu), .KERNEL_SPACE_OK(), .SUPER_SPACE_OK(),
        .USER_SPACE_OK(), .BUS_FAULT_PHYS_ADDRESS(bfa));
    task test_done;
        begin
            $display("checks %0d errors %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task xfer(input [3:0] a, input w, input [31:0] d);
        begin
            @(posedge clk);
            a_addr <= a;
            a_wd <= d;
            a_wr <= w;
            a_rd <= !w;
            @(posedge clk);
            while (wait_req !== 1'b0) @(posedge clk);
            // Read data is taken at the edge that sees waitrequest low
            rdat = rd_data;
            a_wr <= 1'b0;
            a_rd <= 1'b0;
        end
    endtask
    task rchk(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            xfer(a, 1'b0, 32'h00000000);
            rdat = rdat & m;
            `CHK("read", e, rdat)
        end
    endtask
    task ev_take(input [5:0] e, input [11:0] l, input x);
        begin
            cpusc_pipe_inst.pulse(e, l, 32'h00000000);
            #1;
            `CHK("take", x, take)
        end
    endtask
    // Whole run is under two hundred cycles; the limit leaves wide margin
    initial begin
        #50000;
        error_cnt = error_cnt + 1;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(4'hC, 32'hFFFFFFFF, 32'h00400004);
        `CHK("kernel", 1'b1, mk)
        xfer(4'hC, 1'b1, 32'hFFFFFFFF);
        rchk(4'hC, 32'hFFFFFFFF, 32'hF4C79C1F);
        `CHK("vectors", 7'h7F, {fp32, dvb, gvb, cu})
        xfer(4'hD, 1'b1, 32'hFFFFFFFF);
        rchk(4'hD, 32'hFFFFFFFF, 32'h00000000);
        rchk(4'h0, 32'hFFFFFFFF, 32'h00000000);
        for (k = 0; k < 4; k = k + 1) begin
            xfer(4'hC, 1'b1, k << 3);
            #1;
            `CHK("mode", (k == 1) ? 3'h2 : (k == 2) ? 3'h1 : 3'h4, {mk, ms, mu})
            `CHK("usable", {3'h0, k != 1 && k != 2}, cu)
        end
        xfer(4'hC, 1'b1, 32'h00000012);
        #1;
        `CHK("level kernel", 1'b1, mk)
        // Software keeps reserved bits zero from here on
        xfer(4'hC, 1'b1, 32'h00018001);
        ev_take(6'h00, 12'h800, 1'b1);
        rchk(4'hD, 32'h00008C00, 32'h00008000);
        ev_take(6'h02, 12'h800, 1'b0);
        ev_take(6'h01, 12'h800, 1'b1);
        xfer(4'hC, 1'b1, 32'h00018005);
        ev_take(6'h00, 12'h800, 1'b0);
        xfer(4'hC, 1'b1, 32'h00010401);
        ev_take(6'h00, 12'h800, 1'b0);
        ev_take(6'h00, 12'h200, 1'b1);
        xfer(4'hC, 1'b1, 32'h00018011);
        ev_take(6'h02, 12'h800, 1'b1);
        xfer(4'hC, 1'b1, 32'h00038011);
        ev_take(6'h02, 12'h800, 1'b0);
        xfer(4'hC, 1'b1, 32'h00000000);
        cpusc_pipe_inst.pulse(6'h08, 12'h000, 32'hA5A50F0F);
        rchk(4'hC, 32'h00001000, 32'h00001000);
        cpusc_pipe_inst.pulse(6'h08, 12'h000, 32'h12345678);
        #1;
        `CHK("fault address", 32'hA5A50F0F, bfa)
        for (k = 0; k < 4; k = k + 1) begin
            xfer(4'hC, 1'b1, 32'h00000000);
            cpusc_pipe_inst.pulse(6'h20, 12'h080 | k, 32'h00000000);
            rchk(4'hD, 32'h40070000, 32'h40000000 | (k << 16));
            rchk(4'hC, 32'h00000004, 32'h00000004);
        end
        xfer(4'hC, 1'b1, 32'h00000000);
        cpusc_pipe_inst.pulse(6'h10, 12'h0B0, 32'h00000000);
        rchk(4'hD, 32'hB0000000, 32'hA0000000);
        rchk(4'hC, 32'h00000006, 32'h00000002);
        cpusc_pipe_inst.pulse(6'h10, 12'h000, 32'h00000000);
        rchk(4'hD, 32'h80000000, 32'h00000000);
        xfer(4'hC, 1'b1, 32'h00000000);
        cpusc_pipe_inst.pulse(6'h00, 12'h100, 32'h00000000);
        rchk(4'hC, 32'h00000004, 32'h00000004);
        rchk(4'hD, 32'h00070000, 32'h00030000);
        cpusc_pipe_inst.pulse(6'h04, 12'h040, 32'h00000000);
        rchk(4'hC, 32'h00040000, 32'h00040000);
        cpusc_pipe_inst.pulse(6'h04, 12'h000, 32'h00000000);
        rchk(4'hC, 32'h00040000, 32'h00000000);
        test_done;
    end
endmodule
